/* File: pkg/fdoc_pkg.sv */
package fdoc_pkg;
   // register offsets on the three host address lines
   localparam logic [2:0] CTRL_ADDR     = 3'h2;
   localparam logic [2:0] TYPE_ADDR     = 3'h3;
   // values after hardware reset
   localparam logic [7:0] CTRL_RST      = 8'h00;
   localparam logic [3:0] TYPE_RST      = 4'h0;
   // drive output control field positions
   localparam int         CTRL_SEL_LO   = 0;
   localparam int         CTRL_SRST_BIT = 2;
   localparam int         CTRL_DMA_BIT  = 3;
   localparam int         CTRL_MTR_LO   = 4;
   // drive type register fields
   localparam int         TYPE_EXCH_LO  = 2;
   localparam logic [1:0] TYPE_RSVD_VAL = 2'h3;
   localparam logic [1:0] EXCH_NONE    = 2'h0;
   localparam logic [1:0] EXCH_01      = 2'h1;
   localparam logic [1:0] EXCH_02      = 2'h2;
   // software reset low time, rounded up to whole clocks
   localparam int         CLK_NS       = 50;
   localparam int         SRST_MIN_NS  = 100;
   localparam int         SRST_MIN_CYC = (SRST_MIN_NS + CLK_NS - 1) / CLK_NS;
   // width of the synchronised host bus bundle
   localparam int         BUS_W        = 14;
endpackage

/* File: pkg/fdoc_drv_if.sv */
interface fdoc_drv_if;
   logic [7:0] ctrl_reg;
   logic       four_drive;
   logic [1:0] exch;
   logic [3:0] sel;
   logic [3:0] motor;
   logic [1:0] enc_sel;
   logic       enc_motor;
   modport ctrl (output ctrl_reg, four_drive, exch, input sel, motor, enc_sel, enc_motor);
   modport dec  (input ctrl_reg, four_drive, exch, output sel, motor, enc_sel, enc_motor);
endinterface

/* File: rtl/fdoc_sync.sv */
module fdoc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // levels from outside the domain
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* File: rtl/fdoc_decode.sv */
module fdoc_decode (
   // control register and configuration in, pin levels out
   fdoc_drv_if.dec drv
);
   import fdoc_pkg::*;

   // swap is its own inverse, so it maps logical to physical and back
   function automatic logic [1:0] fdoc_map(input logic [1:0] d,
                                            input logic       s02,
                                            input logic       s01);
      logic [1:0] r;
      r = d;
      if (s02 && d == 2'h0) r = 2'h2;
      if (s02 && d == 2'h2) r = 2'h0;
      if (s01 && d == 2'h0) r = 2'h1;
      if (s01 && d == 2'h1) r = 2'h0;
      return r;
   endfunction

   // four drives disables any exchange
   wire       sw02     = !drv.four_drive && drv.exch == EXCH_02;
   wire       sw01     = !drv.four_drive && drv.exch == EXCH_01;
   wire [1:0] log_sel  = drv.ctrl_reg[CTRL_SEL_LO +: 2];
   wire [3:0] mtr      = drv.ctrl_reg[CTRL_MTR_LO +: 4];
   wire [1:0] phys_sel = fdoc_map(log_sel, sw02, sw01);
   // logical 2 only under the 0/2 exchange, logical 3 never in two-drive mode
   wire       sel_ok   = !log_sel[1] || (log_sel == 2'h2 && sw02); // RULE3 RULE4
   wire [3:0] two_sel  = sel_ok ? (4'h1 << phys_sel) : 4'h0; // RULE4
   wire       mtr_p0   = mtr[fdoc_map(2'h0, sw02, sw01)]; // RULE10 RULE11
   wire       mtr_p1   = mtr[fdoc_map(2'h1, sw02, sw01)]; // RULE10
   wire       mtr_p2   = sw02 && mtr[0]; // RULE11

   // four drives: only the encoded lines move, external logic decodes them
   assign drv.sel       = drv.four_drive ? 4'h0 : two_sel; // RULE3
   assign drv.motor     = drv.four_drive ? 4'h0 : {1'b0, mtr_p2, mtr_p1, mtr_p0}; // RULE3
   assign drv.enc_sel   = drv.four_drive ? log_sel : 2'h0; // RULE1
   assign drv.enc_motor = drv.four_drive && mtr[log_sel]; // RULE1 RULE14
endmodule

/* File: rtl/fdoc_dor_top.sv */
// Operation
// [RULE1] With four drives the encoded select lines carry bits 1:0 and the encoded motor line follows the selected drive's motor bit.
// [RULE2] Software usually writes 1C, 2D, 4E or 8F to select and spin up drive 0, 1, 2 or 3.
// [RULE3] Drive 2 and 3 select and motor outputs exist only with four drives or the 0/2 exchange.
// [RULE4] Select bits 1:0 enable one drive at a time; 10 needs four drives or exchange, 11 needs four drives.
// [RULE5] Bit 2 at 0, its reset value, holds the controller in software reset until written 1.
// [RULE6] Software reset touches only saved command parameters, never this register or the rate registers.
// [RULE7] Software keeps bit 2 low at least 100 ns; two back-to-back writes are enough.
// [RULE8] In AT drive mode bit 3 gates DACK, TC, DRQ and IRQ; at 0 the requests float.
// [RULE9] In the alternate drive mode bit 3 is ignored and those signals stay enabled, even in reset.
// [RULE10] With two drives bits 4 and 5 drive the motor outputs of drives 0 and 1 directly.
// [RULE11] Bit 6 drives the drive 2 motor under exchange or four drives; bit 7 drives 3 only with four.
// [RULE12] The drive type register is read/write; AT mode floats bits 7-2 on read, enhanced defines all.
// [RULE13] The control register loads 00h on hardware reset only and may be written at any time.
// [RULE14] Undecoded four-drive patterns enable no select or motor output.
// [RULE15] Reading the control register returns the last value written with no side effect.
module fdoc_dor_top (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   // host bus pins
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [2:0] addr_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic      [7:0] data_oe_out,
   // configuration from the same clock domain
   input  wire logic       four_drive_in,
   input  wire logic       enh_tdr_in,
   input  wire logic       at_mode_in,
   input  wire logic [3:0] drive_id_in,
   // drive interface
   output logic      [3:0] drive_sel_out,
   output logic      [3:0] motor_out,
   output logic      [1:0] encoded_select_lines_out,
   output logic            encoded_motor_line_out,
   // controller core
   output logic            soft_rst_out,
   input  wire logic       drq_in,
   input  wire logic       irq_in,
   output logic            drq_out,
   output logic            drq_oe_out,
   output logic            irq_out,
   output logic            irq_oe_out,
   // dma pins
   input  wire logic       dack_n_in,
   input  wire logic       tc_in,
   output logic            dack_n_out,
   output logic            tc_out
);
   import fdoc_pkg::*;

   logic [fdoc_pkg::BUS_W-1:0] bus_sync;
   logic [1:0]                 dma_sync;
   logic                       wr_q;
   logic [7:0]                 drive_motor_output_control;
   logic [3:0]                 drive_type_register;

   fdoc_drv_if drv ();

   // strobe pins are inverted to active high first so reset zeros mean idle
   fdoc_sync #(
      .WIDTH(BUS_W)
   ) u_bus_sync (
      .clk_in   (core_clk_in),
      .rst_in   (sys_rst_in),
      .async_in ({~cs_n_in, ~rd_n_in, ~wr_n_in, addr_in, data_in}),
      .sync_out (bus_sync)
   );

   fdoc_sync #(
      .WIDTH(2)
   ) u_dma_sync (
      .clk_in   (core_clk_in),
      .rst_in   (sys_rst_in),
      .async_in ({~dack_n_in, tc_in}),
      .sync_out (dma_sync)
   );

   fdoc_decode u_decode (
      .drv (drv.dec)
   );

   // synchronised bus fields
   wire       cs_s    = bus_sync[13];
   wire       rd_s    = bus_sync[12];
   wire       wr_s    = bus_sync[11];
   wire [2:0] addr_s  = bus_sync[10:8];
   wire [7:0] data_s  = bus_sync[7:0];
   wire       dack_s  = dma_sync[1];
   wire       tc_s    = dma_sync[0];

   // data and strobe share sync depth, so the data is settled at the edge
   wire       wr_evt  = cs_s && wr_s && !wr_q;
   wire       wr_ctrl = wr_evt && addr_s == CTRL_ADDR; // RULE13
   wire       wr_type = wr_evt && addr_s == TYPE_ADDR; // RULE12
   wire       rd_act  = cs_s && rd_s && !wr_s;
   wire       rd_ctrl = rd_act && addr_s == CTRL_ADDR;
   wire       rd_type = rd_act && addr_s == TYPE_ADDR;

   // drive type register read view
   wire [1:0] id_sel  = drive_motor_output_control[CTRL_SEL_LO +: 2];
   wire [1:0] drv_id  = id_sel[0] ? drive_id_in[3:2] : drive_id_in[1:0];
   wire [7:0] type_rd = enh_tdr_in ? {TYPE_RSVD_VAL, drv_id, drive_type_register}
                                   : {6'h00, drive_type_register[1:0]};
   wire [7:0] type_oe = enh_tdr_in ? 8'hff : 8'h03; // RULE12

   wire [7:0] next_data_out = rd_ctrl ? drive_motor_output_control : // RULE15
                              rd_type ? type_rd : 8'h00;
   wire [7:0] next_data_oe  = rd_ctrl ? 8'hff : rd_type ? type_oe : 8'h00;

   // dma gating: alternate mode ignores the gate bit entirely
   wire       dma_on  = !at_mode_in || drive_motor_output_control[CTRL_DMA_BIT]; // RULE8 RULE9

   assign drv.ctrl_reg   = drive_motor_output_control;
   assign drv.four_drive = four_drive_in;
   assign drv.exch       = enh_tdr_in ? drive_type_register[TYPE_EXCH_LO +: 2] : EXCH_NONE;

   // register file; only the hardware reset clears it
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         drive_motor_output_control <= CTRL_RST; // RULE13
         drive_type_register        <= TYPE_RST;
      end else begin
         if (wr_ctrl) begin
            drive_motor_output_control <= data_s; // RULE13 RULE6
         end
         if (wr_type) begin
            drive_type_register <= data_s[3:0]; // RULE12
         end
      end
   end

   // host bus read path and write edge
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wr_q        <= 1'b0;
         data_out    <= 8'h00;
         data_oe_out <= 8'h00;
      end else begin
         wr_q        <= wr_s;
         data_out    <= next_data_out;
         data_oe_out <= next_data_oe;
      end
   end

   // drive pins, software reset
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         drive_sel_out            <= 4'h0;
         motor_out                <= 4'h0;
         encoded_select_lines_out <= 2'h0;
         encoded_motor_line_out   <= 1'b0;
         soft_rst_out             <= 1'b1;
      end else begin
         drive_sel_out            <= drv.sel; // RULE4
         motor_out                <= drv.motor; // RULE10 RULE11
         encoded_select_lines_out <= drv.enc_sel; // RULE1
         encoded_motor_line_out   <= drv.enc_motor; // RULE1
         soft_rst_out             <= !drive_motor_output_control[CTRL_SRST_BIT]; // RULE5
      end
   end

   // a synchronous reset may look at the mode pin, so the alternate mode stays enabled
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         drq_oe_out <= !at_mode_in; // RULE9
         irq_oe_out <= !at_mode_in; // RULE9
         drq_out    <= 1'b0;
         irq_out    <= 1'b0;
         dack_n_out <= 1'b1;
         tc_out     <= 1'b0;
      end else begin
         drq_oe_out <= dma_on; // RULE8
         irq_oe_out <= dma_on; // RULE8
         drq_out    <= dma_on && drq_in;
         irq_out    <= dma_on && irq_in;
         dack_n_out <= !(dma_on && dack_s); // RULE8
         tc_out     <= dma_on && tc_s; // RULE8
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_ctrl_hw_clear: assert property ( // RULE13
      $fell(sys_rst_in) |-> drive_motor_output_control == CTRL_RST)
      else $error("control register not cleared by hardware reset");

   a_ctrl_write_load: assert property ( // RULE13
      wr_ctrl |=> drive_motor_output_control == $past(data_s))
      else $error("control register did not take written byte");

   a_soft_rst_hold: assert property ( // RULE5
      wr_ctrl && !data_s[CTRL_SRST_BIT] |=> ##1 soft_rst_out)
      else $error("software reset not asserted after bit 2 cleared");

   a_read_returns: assert property ( // RULE15
      rd_ctrl && !wr_evt |=> data_out == $past(drive_motor_output_control)
                            && data_oe_out == 8'hff && $stable(drive_motor_output_control))
      else $error("control register read wrong or disturbed");

   a_at_dma_gate: assert property ( // RULE8
      at_mode_in && !drive_motor_output_control[CTRL_DMA_BIT]
      |=> !drq_oe_out && !irq_oe_out && dack_n_out && !tc_out)
      else $error("dma signals not gated in AT mode");

   a_alt_dma_on: assert property ( // RULE9
      !at_mode_in |=> drq_oe_out && irq_oe_out)
      else $error("dma signals disabled in alternate mode");

   a_four_encode: assert property ( // RULE1
      four_drive_in |=> encoded_select_lines_out == $past(id_sel)
                        && encoded_motor_line_out
                           == $past(drive_motor_output_control[CTRL_MTR_LO + id_sel]))
      else $error("encoded select or motor line wrong");

   a_four_no_decode: assert property ( // RULE14
      four_drive_in |=> drive_sel_out == 4'h0 && motor_out == 4'h0)
      else $error("decoded outputs active in four-drive mode");

   a_sel_one_hot: assert property ( // RULE4
      $onehot0(drive_sel_out))
      else $error("more than one drive select active");

   a_two_drive_mtr: assert property ( // RULE10
      !four_drive_in && drv.exch == EXCH_NONE
      |=> motor_out == {2'h0, $past(drive_motor_output_control[5:4])})
      else $error("two-drive motor outputs do not follow bits 5:4");

   a_no_drive3: assert property ( // RULE3
      !four_drive_in |=> !drive_sel_out[3] && !motor_out[3])
      else $error("drive 3 output without four drives");

   a_type_write_load: assert property ( // RULE12
      wr_type |=> drive_type_register == $past(data_s[3:0]))
      else $error("drive type register did not take written bits");

   a_type_read_at: assert property ( // RULE12
      rd_type && !enh_tdr_in |=> data_oe_out == 8'h03)
      else $error("drive type read drives bits 7-2 in AT mode");

   a_type_read_enh: assert property ( // RULE12
      rd_type && enh_tdr_in |=> data_oe_out == 8'hff && data_out[7:6] == TYPE_RSVD_VAL)
      else $error("drive type read wrong in enhanced mode");

   a_soft_rst_off: assert property ( // RULE5
      wr_ctrl && data_s[CTRL_SRST_BIT] |=> ##1 !soft_rst_out)
      else $error("software reset not released after bit 2 set");

   a_ctrl_kept: assert property ( // RULE6
      !wr_ctrl |=> $stable(drive_motor_output_control))
      else $error("control register changed without a write");

   a_idle_bus_quiet: assert property ( // RULE15
      !rd_act |=> data_oe_out == 8'h00)
      else $error("data bus driven without a read");

   a_alt_dma_pass: assert property ( // RULE9
      !at_mode_in |=> drq_out == $past(drq_in) && irq_out == $past(irq_in))
      else $error("requests not passed in alternate mode");

   a_at_dma_pass: assert property ( // RULE8
      at_mode_in && drive_motor_output_control[CTRL_DMA_BIT]
      |=> drq_oe_out && irq_oe_out && drq_out == $past(drq_in))
      else $error("requests not enabled with gate bit set");

   a_two_drive_enc: assert property ( // RULE1
      !four_drive_in |=> encoded_select_lines_out == 2'h0 && !encoded_motor_line_out)
      else $error("encoded lines active with two drives");

   a_exch_sel_swap: assert property ( // RULE3
      !four_drive_in && drv.exch == EXCH_02 && id_sel == 2'h0 |=> drive_sel_out == 4'h4)
      else $error("exchanged drive 0 not routed to drive 2 select");

   a_no_sel_three: assert property ( // RULE4
      !four_drive_in && id_sel == 2'h3 |=> drive_sel_out == 4'h0)
      else $error("drive 3 selected with two drives");

   a_exch_mtr_two: assert property ( // RULE11
      !four_drive_in && drv.exch == EXCH_02
      |=> motor_out[2] == $past(drive_motor_output_control[CTRL_MTR_LO]))
      else $error("exchanged motor output wrong");
endmodule

/* File: bench/fdoc_ext_decode.sv */
module fdoc_ext_decode (
   // encoded lines from the controller
   input  wire logic [1:0] enc_sel_in,
   input  wire logic       enc_motor_in,
   input  wire logic       four_drive_in,
   // decoded lines to the drives
   output logic      [3:0] ext_sel_out,
   output logic      [3:0] ext_motor_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] one_hot;
   assign one_hot = 4'h1 << enc_sel_in;
   // idle in two-drive mode: direct pins carry the drives then
   assign ext_sel_out = four_drive_in ? one_hot : 4'h0;
   assign ext_motor_out = (four_drive_in & enc_motor_in) ? one_hot : 4'h0;
endmodule

/* File: bench/fdoc_dor_top_test.sv */
module fdoc_dor_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   import fdoc_pkg::*;
   logic core_clk_in, sys_rst_in, cs_n, rd_n, wr_n, four, enh, at_mode;
   logic drq, irq, dack_n, tc;
   logic [2:0] addr;
   logic [7:0] wdata, data_out, data_oe_out, d, oe;
   logic [3:0] drive_id, drive_sel_out, motor_out, ext_sel, ext_motor;
   logic [1:0] enc_sel;
   logic enc_mtr, soft_rst, drq_o, drq_oe, irq_o, irq_oe, dack_n_o, tc_o;
   int failures, n_compared;
   fdoc_dor_top uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata), .data_out(data_out),
      .data_oe_out(data_oe_out), .four_drive_in(four), .enh_tdr_in(enh), .at_mode_in(at_mode),
      .drive_id_in(drive_id), .drive_sel_out(drive_sel_out), .motor_out(motor_out),
      .encoded_select_lines_out(enc_sel), .encoded_motor_line_out(enc_mtr),
      .soft_rst_out(soft_rst), .drq_in(drq), .irq_in(irq), .drq_out(drq_o),
      .drq_oe_out(drq_oe), .irq_out(irq_o), .irq_oe_out(irq_oe), .dack_n_in(dack_n),
      .tc_in(tc), .dack_n_out(dack_n_o), .tc_out(tc_o));
   fdoc_ext_decode ext (.enc_sel_in(enc_sel), .enc_motor_in(enc_mtr), .four_drive_in(four),
      .ext_sel_out(ext_sel), .ext_motor_out(ext_motor));
   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end
   task automatic report_and_stop;
      $display("compared %0d, failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // strobe held three clocks, released five: syncs need two each way
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk_in);
      #1;
      addr = a;
      wdata = v;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1;
      cs_n = 1'b1;
      wr_n = 1'b1;
      repeat (5) @(posedge core_clk_in);
      #1;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v, output logic [7:0] e);
      @(posedge core_clk_in);
      #1;
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1;
      v = data_out;
      e = data_oe_out;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (4) @(posedge core_clk_in);
      #1;
   endtask
   task automatic drv(input logic [7:0] v, input logic [3:0] s, input logic [3:0] m);
      wr(CTRL_ADDR, v);
      chk({4'h0, drive_sel_out}, {4'h0, s});
      chk({4'h0, motor_out}, {4'h0, m});
   endtask
   task automatic dma(input logic en);
      chk({7'h0, drq_oe}, {7'h0, en});
      chk({7'h0, irq_oe}, {7'h0, en});
      chk({5'h0, irq_o, drq_o, tc_o}, {5'h0, en, en, en});
      chk({7'h0, dack_n_o}, {7'h0, ~en});
   endtask
   task automatic do_reset;
      sys_rst_in = 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      sys_rst_in = 1'b0;
   endtask
   initial begin
      #200us;
      failures++;
      report_and_stop();
   end
   initial begin
      failures = 0;
      n_compared = 0;
      {cs_n, rd_n, wr_n, four, enh, at_mode} = 6'b111001;
      {drq, irq, dack_n, tc} = 4'b1101;
      addr = 3'h0;
      wdata = 8'h00;
      drive_id = 4'h9;
      do_reset();
      chk({7'h0, soft_rst}, 8'h01);
      rd(CTRL_ADDR, d, oe);
      chk(d, CTRL_RST);
      dma(1'b0);
      // 1C and 2D select and spin up one drive, 31 spins two, 4E and 8F enable nothing unexchanged
      drv(8'h1c, 4'h1, 4'h1);
      chk({7'h0, soft_rst}, 8'h00);
      dma(1'b1);
      drv(8'h2d, 4'h2, 4'h2);
      drv(8'h31, 4'h2, 4'h3);
      drv(8'h4e, 4'h0, 4'h0);
      drv(8'h8f, 4'h0, 4'h0);
      // set bit 2, clear it and read the register back, then set it again
      wr(CTRL_ADDR, 8'h1c);
      drv(8'h18, 4'h1, 4'h1);
      chk({7'h0, soft_rst}, 8'h01);
      rd(CTRL_ADDR, d, oe);
      chk(d, 8'h18);
      chk(oe, 8'hff);
      drv(8'h1c, 4'h1, 4'h1);
      chk({7'h0, soft_rst}, 8'h00);
      wr(CTRL_ADDR, 8'h14);
      dma(1'b0);
      at_mode = 1'b0;
      repeat (4) @(posedge core_clk_in);
      #1;
      dma(1'b1);
      sys_rst_in = 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk({6'h0, drq_oe, irq_oe}, 8'h03);
      chk({5'h0, irq_o, drq_o, tc_o}, 8'h00);
      chk({7'h0, dack_n_o}, 8'h01);
      chk({7'h0, soft_rst}, 8'h01);
      sys_rst_in = 1'b0;
      rd(CTRL_ADDR, d, oe);
      chk(d, CTRL_RST);
      at_mode = 1'b1;
      enh = 1'b1;
      wr(TYPE_ADDR, 8'h0b);
      drv(8'h4e, 4'h1, 4'h1);
      drv(8'h1c, 4'h4, 4'h4);
      rd(TYPE_ADDR, d, oe);
      chk(d, 8'hdb);
      chk(oe, 8'hff);
      enh = 1'b0;
      rd(TYPE_ADDR, d, oe);
      chk(d & 8'h03, 8'h03);
      chk(oe, 8'h03);
      four = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_ADDR, (8'h10 << i) | 8'h0c | 8'(i));
         chk({6'h0, enc_sel}, 8'(i));
         chk({7'h0, enc_mtr}, 8'h01);
         chk({ext_sel, ext_motor}, {4'h1 << i, 4'h1 << i});
         chk({drive_sel_out, motor_out}, 8'h00);
         wr(CTRL_ADDR, 8'hf0 ^ (8'h10 << i) | 8'h0c | 8'(i));
         chk({7'h0, enc_mtr}, 8'h00);
         chk({4'h0, ext_motor}, 8'h00);
      end
      rd(3'h0, d, oe);
      chk(oe, 8'h00);
      report_and_stop();
   end
endmodule
